// file: testbench/asb_host_model.sv
// Host that reaches the buffer registers over the strobe port
`timescale 1ns/100ps
`include "asb_defines.svh"
module asb_host_model
  import asb_pkg::*;
(
  input wire logic core_clk,
  output asb_bus_req_type bus_req,
  input wire logic [7:0] bus_rdata
);
  initial bus_req = '0;
  task automatic wr(input logic [`ASB_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [`ASB_ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    // Data stands only in this cycle
    #1;
    d = bus_rdata;
  endtask
endmodule

// file: testbench/asb_sample_buffer_checker.sv
// Port-level assertions for the sample buffer
`timescale 1ns/100ps
`include "asb_defines.svh"
module asb_sample_buffer_checker
  import asb_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire asb_bus_req_type bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic sample_valid,
  input wire logic watermark_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_rdata_idle;
    !$past(bus_req.rd) |-> bus_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");
  property p_unmapped;
    bus_req.rd && bus_req.addr > `ASB_ADDR_WPTR |=> bus_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_clear_wm;
    bus_req.wr && bus_req.addr == `ASB_ADDR_CLEAR && bus_req.wdata[0] |=> !watermark_irq;
  endproperty
  a_clear_wm: assert property (p_clear_wm)
    else $error("watermark kept after clear");
  property p_wm_rise;
    $rose(watermark_irq) |-> $past(sample_valid || bus_req.wr);
  endproperty
  a_wm_rise: assert property (p_wm_rise)
    else $error("watermark rose without a cause");
  property p_wm_fall;
    $fell(watermark_irq) |-> $past(bus_req.rd || bus_req.wr);
  endproperty
  a_wm_fall: assert property (p_wm_fall)
    else $error("watermark fell without a read or write");
  property p_status_wm;
    bus_req.rd && bus_req.addr == `ASB_ADDR_STATUS |=> bus_rdata[0] == $past(watermark_irq);
  endproperty
  a_status_wm: assert property (p_status_wm)
    else $error("status watermark bit differs from pin");
  property p_level_hi;
    bus_req.rd && bus_req.addr == `ASB_ADDR_LEVEL_HI |=> bus_rdata[7:2] == 6'h00;
  endproperty
  a_level_hi: assert property (p_level_hi)
    else $error("fill level high bits set");
  property p_wptr;
    bus_req.rd && bus_req.addr == `ASB_ADDR_WPTR |=> bus_rdata[7:6] == 2'h0;
  endproperty
  a_wptr: assert property (p_wptr)
    else $error("write pointer out of range");
endmodule

// file: testbench/asb_sample_buffer_test.sv
// Self-checking bench for the sample buffer
`timescale 1ns/100ps
`include "asb_defines.svh"
module asb_sample_buffer_test
  import asb_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  asb_bus_req_type bus_req;
  logic [7:0] bus_rdata;
  logic sample_valid = 1'b0;
  asb_sample_type sample_data = '0;
  logic engine_irq = 1'b0;
  logic external_trigger_pin = 1'b0;
  logic watermark_irq;
  int num_errors = 0;
  int tests_run = 0;
  logic [7:0] rv;
  always #5 core_clk = ~core_clk;
  asb_host_model host (.core_clk(core_clk), .bus_req(bus_req), .bus_rdata(bus_rdata));
  asb_sample_buffer DUT (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .sample_valid(sample_valid), .sample_data(sample_data),
    .engine_irq(engine_irq), .external_trigger_pin(external_trigger_pin),
    .watermark_irq(watermark_irq));
  // Sample n carries n in each upper byte so low resolution still names it
  function automatic asb_sample_type smp(input logic [7:0] n);
    return '{z: {n, 8'h33}, y: {n, 8'h22}, x: {n, 8'h11}};
  endfunction
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    host.rd(a, rv);
    chk(what, {2'b00, rv}, {2'b00, exp});
  endtask
  task automatic rsmp(input logic [7:0] n, input logic hi);
    for (int k = 1; k < 4; k++) begin
      if (hi) rchk(`ASB_ADDR_DATA, 8'(8'h11 * k), "low_byte");
      rchk(`ASB_ADDR_DATA, n, "high_byte");
    end
  endtask
  task automatic push(input int first, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      sample_valid <= 1'b1;
      sample_data <= smp(8'(first + i));
    end
    @(posedge core_clk);
    sample_valid <= 1'b0;
    #1;
  endtask
  task automatic summarize();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    rchk(`ASB_ADDR_WPTR, 8'h00, "wptr_reset");
    rchk(`ASB_ADDR_STATUS, 8'h00, "status_reset");
    host.wr(`ASB_ADDR_CTRL, 8'h04);
    host.wr(`ASB_ADDR_THRESH, 8'h03);
    push(0, 2);
    chk("wm_below", {9'h0, watermark_irq}, 10'h000);
    push(2, 1);
    chk("wm_at", {9'h0, watermark_irq}, 10'h001);
    rchk(`ASB_ADDR_LEVEL_LO, 8'h12, "level");
    rchk(`ASB_ADDR_WPTR, 8'h03, "wptr");
    rsmp(8'h00, 1'b1);
    chk("wm_after_pop", {9'h0, watermark_irq}, 10'h000);
    rsmp(8'h01, 1'b1);
    rchk(4'hf, 8'h00, "unmapped");
    host.wr(`ASB_ADDR_CLEAR, 8'h01);
    rchk(`ASB_ADDR_LEVEL_LO, 8'h00, "level_clear");
    push(0, 65);
    rchk(`ASB_ADDR_STATUS, 8'h05, "fifo_full");
    rchk(`ASB_ADDR_LEVEL_LO, 8'h80, "full_lo");
    rchk(`ASB_ADDR_LEVEL_HI, 8'h01, "full_hi");
    rsmp(8'h00, 1'b1);
    host.wr(`ASB_ADDR_CLEAR, 8'h01);
    host.wr(`ASB_ADDR_CTRL, 8'h01);
    push(0, 66);
    rsmp(8'h02, 1'b0);
    rchk(`ASB_ADDR_WPTR, 8'h02, "stream_wptr");
    rchk(`ASB_ADDR_LEVEL_LO, 8'hbd, "low_level");
    host.wr(`ASB_ADDR_CLEAR, 8'h01);
    host.wr(`ASB_ADDR_CTRL, 8'h06);
    host.wr(`ASB_ADDR_THRESH, 8'h04);
    push(0, 10);
    chk("wm_trigger", {9'h0, watermark_irq}, 10'h000);
    rchk(`ASB_ADDR_LEVEL_LO, 8'h18, "pre_level");
    @(posedge core_clk);
    engine_irq <= 1'b1;
    @(posedge core_clk);
    engine_irq <= 1'b0;
    rchk(`ASB_ADDR_STATUS, 8'h0a, "captured");
    push(10, 70);
    rchk(`ASB_ADDR_STATUS, 8'h0e, "post_full");
    rchk(`ASB_ADDR_ABOVE, 8'h3c, "above_post");
    rsmp(8'h06, 1'b1);
    host.wr(`ASB_ADDR_CLEAR, 8'h01);
    rchk(`ASB_ADDR_STATUS, 8'h00, "rearm");
    rchk(`ASB_ADDR_WPTR, 8'h00, "wptr_clear");
    @(posedge core_clk);
    external_trigger_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    external_trigger_pin <= 1'b0;
    rchk(`ASB_ADDR_STATUS, 8'h08, "pin_trigger");
    host.wr(`ASB_ADDR_CTRL, 8'h03);
    rchk(`ASB_ADDR_CTRL, 8'h03, "ctrl_code3");
    push(0, 4);
    rchk(`ASB_ADDR_STATUS, 8'h01, "code3_fifo");
    host.wr(`ASB_ADDR_THRESH, 8'h05);
    rchk(`ASB_ADDR_STATUS, 8'h00, "thresh_raised");
    rchk(`ASB_ADDR_THRESH, 8'h05, "thresh_read");
    summarize();
  end
endmodule
bind asb_sample_buffer asb_sample_buffer_checker chk_i (.core_clk(core_clk), .sys_rst(sys_rst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .sample_valid(sample_valid),
  .watermark_irq(watermark_irq));

// file: verilog/asb_defines.svh
// Register offsets, field positions, reset values and sizes of the sample buffer
`ifndef ASB_DEFINES_SVH
`define ASB_DEFINES_SVH

`define ASB_ADDR_W 4
`define ASB_PTR_W 6
`define ASB_CNT_W 7
`define ASB_DEPTH_SAMPLES 7'h40

`define ASB_ADDR_CTRL 4'h0
`define ASB_ADDR_THRESH 4'h1
`define ASB_ADDR_LEVEL_LO 4'h2
`define ASB_ADDR_LEVEL_HI 4'h3
`define ASB_ADDR_STATUS 4'h4
`define ASB_ADDR_ABOVE 4'h5
`define ASB_ADDR_DATA 4'h6
`define ASB_ADDR_CLEAR 4'h7
`define ASB_ADDR_WPTR 4'h8

`define ASB_CTRL_MODE_LSB 0
`define ASB_CTRL_MODE_MSB 1
`define ASB_CTRL_RES_BIT 2
`define ASB_CLEAR_BIT 0

`define ASB_ST_WATERMARK 0
`define ASB_ST_CAPTURED 1
`define ASB_ST_FULL 2
`define ASB_ST_TRIGGERED 3

`define ASB_MODE_RESET 2'h0
`define ASB_THRESH_RESET 8'h00

`define ASB_BPS_LOW 10'h003
`define ASB_BPS_HIGH 10'h006
`define ASB_LAST_LOW 3'h2
`define ASB_LAST_HIGH 3'h5

`endif

// file: verilog/asb_pkg.sv
// Types shared by the sample buffer modules
`include "asb_defines.svh"
package asb_pkg;

  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } asb_sample_type;

  typedef struct packed {
    logic [`ASB_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } asb_bus_req_type;

  typedef enum logic [1:0] {
    ASB_FIFO,
    ASB_STREAM,
    ASB_TRIGGER
  } asb_mode_type;

endpackage

// file: verilog/asb_sample_buffer.sv
// Accelerometer sample buffer with FIFO, stream and trigger modes
//
// Contract
// - Samples read out bytewise, x first; x low byte first at high resolution, x upper byte first at low.
// - Whole samples stored; write pointer marks next slot.
// - FIFO/stream: watermark when count reaches threshold.
// - Trigger pre-event: fill to threshold, then evict.
// - After trigger: stop evicting, append until full.
// - Append past threshold; FIFO/trigger stop when full.
// - Stream full: new sample evicts oldest.
// - Reading a whole sample removes the oldest.
// - Resolution select: one or two bytes per axis.
// - Watermark holds until count drops below threshold.
// - Engine interrupt or trigger pin starts trigger.
// - Captured flag on engine interrupt at threshold.
`timescale 1ns/100ps
`include "asb_defines.svh"
module asb_sample_buffer
  import asb_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire asb_bus_req_type bus_req,
  output logic [7:0] bus_rdata,
  input wire logic sample_valid,
  input wire asb_sample_type sample_data,
  input wire logic engine_irq,
  input wire logic external_trigger_pin,
  output logic watermark_irq
);

  // Registered state
  logic [1:0] mode_field;
  logic resolution_select;
  logic [7:0] pretrigger_threshold_field;
  logic [`ASB_CNT_W-1:0] count;
  logic [`ASB_PTR_W-1:0] wr_ptr;
  logic [`ASB_PTR_W-1:0] rd_ptr;
  logic [2:0] byte_idx;
  logic triggered;
  logic trigger_captured_flag;
  logic [7:0] rdata;

  // Next values
  logic [1:0] next_mode_field;
  logic next_resolution_select;
  logic [7:0] next_pretrigger_threshold_field;
  logic [`ASB_CNT_W-1:0] next_count;
  logic [`ASB_PTR_W-1:0] next_wr_ptr;
  logic [`ASB_PTR_W-1:0] next_rd_ptr;
  logic [2:0] next_byte_idx;
  logic next_triggered;
  logic next_trigger_captured_flag;
  logic [7:0] next_rdata;
  logic next_watermark_irq;

  // Decoded and combinational values
  logic ext_trigger_sync;
  asb_sample_type head_sample;
  asb_mode_type mode;
  asb_mode_type next_mode;
  logic clear_req;
  logic data_read;
  logic last_byte;
  logic pop;
  logic store;
  logic evict;
  logic trigger_event;
  logic at_threshold;
  logic [`ASB_CNT_W-1:0] cnt_after_pop;
  logic [9:0] fill_level_field;
  logic [7:0] samples_above_threshold;
  logic [7:0] head_byte;
  logic [7:0] status_byte;

  // The pin is asynchronous; nothing reads it before the second flop
  asb_sync2 u_trigger_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(external_trigger_pin),
    .sync_out(ext_trigger_sync)
  );

  // A sample arriving in a clear cycle is dropped rather than written
  asb_sample_mem u_mem (
    .core_clk(core_clk),
    .wr_en(store && !clear_req),
    .wr_addr(wr_ptr),
    .wr_data(sample_data),
    .rd_addr(rd_ptr),
    .rd_data(head_sample)
  );

  // Mode code 3 is not defined and behaves as FIFO
  always_comb begin
    unique case (mode_field)
      2'h1: mode = ASB_STREAM;
      2'h2: mode = ASB_TRIGGER;
      default: mode = ASB_FIFO;
    endcase
  end

  // Byte of the head sample selected by the read position
  always_comb begin
    head_byte = 8'h00;
    if (resolution_select) begin
      unique case (byte_idx)
        3'h0: head_byte = head_sample.x[7:0];
        3'h1: head_byte = head_sample.x[15:8];
        3'h2: head_byte = head_sample.y[7:0];
        3'h3: head_byte = head_sample.y[15:8];
        3'h4: head_byte = head_sample.z[7:0];
        3'h5: head_byte = head_sample.z[15:8];
        default: head_byte = 8'h00;
      endcase
    end else begin
      // Low resolution keeps the upper byte of each axis
      unique case (byte_idx)
        3'h0: head_byte = head_sample.x[15:8];
        3'h1: head_byte = head_sample.y[15:8];
        3'h2: head_byte = head_sample.z[15:8];
        default: head_byte = 8'h00;
      endcase
    end
  end

  // Settings written by the host; a clear leaves them as they are
  always_comb begin
    next_mode_field = mode_field;
    next_resolution_select = resolution_select;
    next_pretrigger_threshold_field = pretrigger_threshold_field;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `ASB_ADDR_CTRL: begin
          next_mode_field = bus_req.wdata[`ASB_CTRL_MODE_MSB:`ASB_CTRL_MODE_LSB];
          next_resolution_select = bus_req.wdata[`ASB_CTRL_RES_BIT];
        end
        `ASB_ADDR_THRESH: next_pretrigger_threshold_field = bus_req.wdata;
        default: ;
      endcase
    end
    clear_req = bus_req.wr && (bus_req.addr == `ASB_ADDR_CLEAR)
                && bus_req.wdata[`ASB_CLEAR_BIT];
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_field <= `ASB_MODE_RESET;
      resolution_select <= 1'b0;
      pretrigger_threshold_field <= `ASB_THRESH_RESET;
    end else begin
      mode_field <= next_mode_field;
      resolution_select <= next_resolution_select;
      pretrigger_threshold_field <= next_pretrigger_threshold_field;
    end
  end

  // Buffer state: pointers, count, read position and trigger flags
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_byte_idx = byte_idx;
    store = 1'b0;
    evict = 1'b0;

    // Host side: each data read advances one byte, the last byte pops the sample
    data_read = bus_req.rd && (bus_req.addr == `ASB_ADDR_DATA) && (count != '0);
    last_byte = byte_idx == (resolution_select ? `ASB_LAST_HIGH : `ASB_LAST_LOW);
    pop = data_read && last_byte;
    cnt_after_pop = count - {{(`ASB_CNT_W-1){1'b0}}, pop};
    at_threshold = {1'b0, cnt_after_pop} >= pretrigger_threshold_field;

    // Sample side; decided on the count left after a same-cycle pop
    if (sample_valid) begin
      unique case (mode)
        ASB_FIFO: store = cnt_after_pop != `ASB_DEPTH_SAMPLES;
        ASB_STREAM: begin
          store = 1'b1;
          evict = cnt_after_pop == `ASB_DEPTH_SAMPLES;
        end
        ASB_TRIGGER: begin
          if (triggered) begin
            store = cnt_after_pop != `ASB_DEPTH_SAMPLES;
          end else if (pretrigger_threshold_field != 8'h00) begin
            // A threshold above the depth behaves as a full buffer
            store = 1'b1;
            evict = at_threshold || (cnt_after_pop == `ASB_DEPTH_SAMPLES);
          end
        end
      endcase
    end

    if (store) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    next_rd_ptr = rd_ptr + {{(`ASB_PTR_W-1){1'b0}}, pop}
                  + {{(`ASB_PTR_W-1){1'b0}}, evict};
    next_count = cnt_after_pop + {{(`ASB_CNT_W-1){1'b0}}, store}
                 - {{(`ASB_CNT_W-1){1'b0}}, evict};

    if (pop) begin
      next_byte_idx = 3'h0;
    end else if (evict) begin
      // A partly read sample that is evicted restarts reading on the new head
      next_byte_idx = 3'h0;
    end else if (data_read) begin
      next_byte_idx = byte_idx + 3'h1;
    end

    trigger_event = (mode == ASB_TRIGGER) && (engine_irq || ext_trigger_sync);
    // Set wins over clear so an event in the clear cycle is kept
    next_triggered = (triggered && !clear_req && (mode == ASB_TRIGGER)) || trigger_event;
    next_trigger_captured_flag = (trigger_captured_flag && !clear_req)
      || (engine_irq && ({1'b0, count} >= pretrigger_threshold_field));

    if (clear_req) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
      next_byte_idx = 3'h0;
    end
  end

  // Fill level in bytes, and samples held beyond the threshold
  always_comb begin
    fill_level_field = {{(10-`ASB_CNT_W){1'b0}}, count}
                       * (resolution_select ? `ASB_BPS_HIGH : `ASB_BPS_LOW);
    if ({1'b0, count} >= pretrigger_threshold_field) begin
      samples_above_threshold = {1'b0, count} - pretrigger_threshold_field;
    end else begin
      samples_above_threshold = 8'h00;
    end
    status_byte = 8'h00;
    status_byte[`ASB_ST_WATERMARK] = watermark_irq;
    status_byte[`ASB_ST_CAPTURED] = trigger_captured_flag;
    status_byte[`ASB_ST_FULL] = count == `ASB_DEPTH_SAMPLES;
    status_byte[`ASB_ST_TRIGGERED] = triggered;
  end

  // Read data: registered, and zero in every cycle that does not follow a read
  always_comb begin
    next_rdata = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `ASB_ADDR_CTRL: next_rdata = {5'h00, resolution_select, mode_field};
        `ASB_ADDR_THRESH: next_rdata = pretrigger_threshold_field;
        `ASB_ADDR_LEVEL_LO: next_rdata = fill_level_field[7:0];
        `ASB_ADDR_LEVEL_HI: next_rdata = {6'h00, fill_level_field[9:8]};
        `ASB_ADDR_STATUS: next_rdata = status_byte;
        `ASB_ADDR_ABOVE: next_rdata = samples_above_threshold;
        `ASB_ADDR_DATA: next_rdata = (count != '0) ? head_byte : 8'h00;
        `ASB_ADDR_WPTR: next_rdata = {{(8-`ASB_PTR_W){1'b0}}, wr_ptr};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Pointers wrap at the depth; the count tells full from empty
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      byte_idx <= 3'h0;
      triggered <= 1'b0;
      trigger_captured_flag <= 1'b0;
    end else begin
      count <= next_count;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      byte_idx <= next_byte_idx;
      triggered <= next_triggered;
      trigger_captured_flag <= next_trigger_captured_flag;
    end
  end

  // Watermark uses the settings that take effect at this edge, so a mode or
  // threshold write moves it together with the write and not a cycle later
  always_comb begin
    unique case (next_mode_field)
      2'h1: next_mode = ASB_STREAM;
      2'h2: next_mode = ASB_TRIGGER;
      default: next_mode = ASB_FIFO;
    endcase
    // Level output, so it falls by itself once the count is below threshold
    next_watermark_irq = ((next_mode == ASB_FIFO) || (next_mode == ASB_STREAM))
      && (next_pretrigger_threshold_field != 8'h00)
      && ({1'b0, next_count} >= next_pretrigger_threshold_field);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      watermark_irq <= 1'b0;
    end else begin
      watermark_irq <= next_watermark_irq;
    end
  end

  assign bus_rdata = rdata;

endmodule

// file: verilog/asb_sample_mem.sv
// Sample storage array: one synchronous write port, one asynchronous read port
`timescale 1ns/100ps
`include "asb_defines.svh"
module asb_sample_mem
  import asb_pkg::*;
(
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [`ASB_PTR_W-1:0] wr_addr,
  input wire asb_sample_type wr_data,
  input wire logic [`ASB_PTR_W-1:0] rd_addr,
  output asb_sample_type rd_data
);

  asb_sample_type mem [0:(1<<`ASB_PTR_W)-1];

  // No reset: slots are only read once counted as stored
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule

// file: verilog/asb_sync2.sv
// Two flip-flop synchroniser for a level arriving from a pin
`timescale 1ns/100ps
module asb_sync2 (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic sync_out
);

  logic stage1;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
